// ---- lcs_pkg.sv ----
/*
 * lcs_pkg: constants for the loop controller status flag block.
 * assumes a 40 MHz single clock and a plain register port.
 */
package lcs_pkg;

    // ------------------------------------------------------------
    // clock and refresh timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned REFRESH_MS     = 1000;
    localparam int unsigned REFRESH_CYCLES = CLK_HZ / 1000 * REFRESH_MS;
    localparam int          CNT_W          = 26;

    // ------------------------------------------------------------
    // register port and map (word indices)
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 16;
    localparam logic [3:0]  ADR_NONFATAL   = 4'h0;
    localparam logic [3:0]  ADR_LOOP       = 4'h1;
    localparam logic [3:0]  ADR_IRQ_STAT   = 4'h2;
    localparam logic [3:0]  ADR_IRQ_MASK   = 4'h3;
    localparam logic [15:0] WORD_RESET     = 16'h0000;
    localparam logic [15:0] UNMAPPED_VAL   = 16'h0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NF_RIGHT    = 6;
    localparam int NF_LEFT     = 7;
    localparam int LS_PV_ERR   = 1;
    localparam int LS_MV_ERR   = 2;
    localparam int LS_EXEC_ERR = 3;
    localparam int LS_RAM_ERR  = 4;
    localparam int LS_AUTO_CS  = 7;
    localparam int LS_RUN      = 11;
    localparam int LS_BACKUP   = 13;
    localparam int LS_CHANGED  = 15;

    // interrupt status bits
    localparam int IRQ_W       = 5;
    localparam int IQ_NONFATAL = 0;
    localparam int IQ_EXEC     = 1;
    localparam int IQ_RAM      = 2;
    localparam int IQ_AUTO_CS  = 3;
    localparam int IQ_CHANGED  = 4;

    // function blocks observed for execution errors
    localparam int NUM_BLOCKS  = 8;
    localparam int CODE_W      = 16;

    // start request modes
    localparam logic START_HOT  = 1'b0;
    localparam logic START_COLD = 1'b1;

    typedef enum logic [2:0] {
        ST_STOP,
        ST_CHECK,
        ST_COPY,
        ST_RUN
    } lcs_state_e;

endpackage

// ---- lcs_flags.sv ----
/*
 * lcs_flags: status flag logic reporting controller condition to a host.
 * assumes all inputs come from logic on clk; host reads the two status words
 * and reads and writes the interrupt status and mask; flash controller answers copy and backup requests.
 */
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - duplex mode: nonfatal word bit 06 follows right board nonfatal error
// - duplex mode: nonfatal word bit 07 follows left board nonfatal error
// - loop word bit 01 mirrors the pv error input item
// - loop word bit 02 mirrors the mv error input item
// - loop word bit 03 set when any block execution code is non-zero
// - loop word bit 04 set while block data in ram is corrupted
// - invalid ram data at start forces cold start even if hot requested
// - ram lost over power-off: automatic cold start and bit 07 set
// - flash backup copied into ram before that automatic cold start
// - automatic cold start bit reads zero whenever not running
// - loop word bit 11 is one while running, zero when stopped
// - loop word bit 13 is one while a backup runs during operation
// - loop word bit 15 set on block download while running
// - changed bit zero without download, cleared by hot or cold start
// - downloads stay in ram; flash written only on backup request
// - status words refreshed on a fixed one second cycle
module lcs_flags
    import lcs_pkg::*;
#(
    parameter int unsigned REFRESH_CNT = lcs_pkg::REFRESH_CYCLES
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // register port
    input  wire logic [lcs_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [lcs_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [lcs_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             irq,
    // duplex board state
    input  wire logic                        duplex_mode,
    input  wire logic                        right_nonfatal,
    input  wire logic                        left_nonfatal,
    // block items
    input  wire logic                        pv_error_input_item,
    input  wire logic                        mv_error_input_item,
    input  wire logic [lcs_pkg::NUM_BLOCKS*lcs_pkg::CODE_W-1:0] execution_error_code_item,
    input  wire logic                        ram_db_invalid,
    input  wire logic                        ram_lost_at_power,
    // run control
    input  wire logic                        start_req,
    input  wire logic                        start_mode,
    input  wire logic                        stop_req,
    output logic                             running,
    output logic                             hot_start,
    output logic                             cold_start,
    // tool and flash
    input  wire logic                        download_strobe,
    input  wire logic                        backup_req,
    output logic                             ram_write_en,
    output logic                             flash_copy_req,
    input  wire logic                        flash_copy_done,
    output logic                             flash_backup_req,
    input  wire logic                        flash_backup_done
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    lcs_state_e             state_r;
    logic [CNT_W-1:0]       tick_cnt_r;
    logic                   tick_r;
    logic                   strap_seen_r;
    logic                   power_lost_r;
    logic                   auto_cs_r;
    logic                   cold_pend_r;
    logic                   backup_busy_r;
    logic                   changed_r;
    logic [NUM_BLOCKS-1:0]  code_nz;
    logic                   exec_err;
    logic                   exec_err_d_r;
    logic                   ram_err_d_r;
    logic                   nf_any;
    logic                   nf_any_d_r;
    logic [DATA_W-1:0]      nf_word_r;
    logic [DATA_W-1:0]      loop_word_r;
    logic [IRQ_W-1:0]       irq_stat_r;
    logic [IRQ_W-1:0]       irq_mask_r;
    logic [IRQ_W-1:0]       irq_ev;
    logic                   start_cold;
    logic                   changed_set;

    // ------------------------------------------------------------
    // execution error detection
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_BLOCKS; g++) begin : g_code
        assign code_nz[g] = |execution_error_code_item[g*CODE_W +: CODE_W];
    end

    assign exec_err = |code_nz;
    assign nf_any   = duplex_mode & (right_nonfatal | left_nonfatal);

    // ------------------------------------------------------------
    // one second refresh tick
    // ------------------------------------------------------------
    // a long count; shorten REFRESH_CNT in simulation
    always_ff @(posedge clk) begin
        if (reset) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else if (tick_cnt_r == CNT_W'(REFRESH_CNT - 1)) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + CNT_W'(1);
            tick_r     <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // power-up ram loss capture
    // ------------------------------------------------------------
    // the strap is taken at the first edge after release, never in reset
    always_ff @(posedge clk) begin
        if (reset) begin
            strap_seen_r <= 1'b0;
            power_lost_r <= 1'b0;
        end else if (!strap_seen_r) begin
            strap_seen_r <= 1'b1;
            power_lost_r <= ram_lost_at_power;
        end else if (state_r == ST_COPY && flash_copy_done) begin
            power_lost_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // run control
    // ------------------------------------------------------------
    assign start_cold = (start_mode == START_COLD) | ram_db_invalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r        <= ST_STOP;
            cold_pend_r    <= 1'b0;
            hot_start      <= 1'b0;
            cold_start     <= 1'b0;
            flash_copy_req <= 1'b0;
            auto_cs_r      <= 1'b0;
        end else begin
            hot_start      <= 1'b0;
            cold_start     <= 1'b0;
            flash_copy_req <= 1'b0;
            unique case (state_r)
                ST_STOP: begin
                    auto_cs_r <= 1'b0;
                    if (start_req && strap_seen_r) begin
                        cold_pend_r <= start_cold;
                        state_r     <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (power_lost_r) begin
                        // restore last backup before the forced cold start
                        flash_copy_req <= 1'b1;
                        state_r        <= ST_COPY;
                    end else begin
                        hot_start  <= ~cold_pend_r;
                        cold_start <= cold_pend_r;
                        state_r    <= ST_RUN;
                    end
                end
                ST_COPY: begin
                    if (flash_copy_done) begin
                        cold_start <= 1'b1;
                        auto_cs_r  <= 1'b1;
                        state_r    <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (stop_req) begin
                        auto_cs_r <= 1'b0;
                        state_r   <= ST_STOP;
                    end
                end
                default: begin
                    state_r <= ST_STOP;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            running <= 1'b0;
        end else begin
            running <= (state_r == ST_RUN) && !stop_req;
        end
    end

    // ------------------------------------------------------------
    // online download and backup
    // ------------------------------------------------------------
    assign changed_set = download_strobe && state_r == ST_RUN;

    // set wins over a start in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            changed_r <= 1'b0;
        end else if (changed_set) begin
            changed_r <= 1'b1;
        end else if (hot_start || cold_start) begin
            changed_r <= 1'b0;
        end
    end

    // downloads go to ram only; flash sees nothing until a backup request
    always_ff @(posedge clk) begin
        if (reset) begin
            ram_write_en <= 1'b0;
        end else begin
            ram_write_en <= download_strobe;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            backup_busy_r    <= 1'b0;
            flash_backup_req <= 1'b0;
        end else begin
            flash_backup_req <= 1'b0;
            if (backup_busy_r) begin
                if (flash_backup_done) begin
                    backup_busy_r <= 1'b0;
                end
            end else if (backup_req && state_r == ST_RUN) begin
                backup_busy_r    <= 1'b1;
                flash_backup_req <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // status words, refreshed on the tick
    // ------------------------------------------------------------
    // host sees at most one second old state; events in between are not kept
    always_ff @(posedge clk) begin
        if (reset) begin
            nf_word_r <= WORD_RESET;
        end else if (tick_r) begin
            nf_word_r           <= WORD_RESET;
            nf_word_r[NF_RIGHT] <= duplex_mode & right_nonfatal;
            nf_word_r[NF_LEFT]  <= duplex_mode & left_nonfatal;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            loop_word_r <= WORD_RESET;
        end else if (tick_r) begin
            loop_word_r              <= WORD_RESET;
            loop_word_r[LS_PV_ERR]   <= pv_error_input_item;
            loop_word_r[LS_MV_ERR]   <= mv_error_input_item;
            loop_word_r[LS_EXEC_ERR] <= exec_err;
            loop_word_r[LS_RAM_ERR]  <= ram_db_invalid;
            loop_word_r[LS_AUTO_CS]  <= auto_cs_r & running;
            loop_word_r[LS_RUN]      <= running;
            loop_word_r[LS_BACKUP]   <= backup_busy_r & running;
            loop_word_r[LS_CHANGED]  <= changed_r;
        end
    end

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            exec_err_d_r <= 1'b0;
            ram_err_d_r  <= 1'b0;
            nf_any_d_r   <= 1'b0;
        end else begin
            exec_err_d_r <= exec_err;
            ram_err_d_r  <= ram_db_invalid;
            nf_any_d_r   <= nf_any;
        end
    end

    always_comb begin
        irq_ev              = '0;
        irq_ev[IQ_NONFATAL] = nf_any & ~nf_any_d_r;
        irq_ev[IQ_EXEC]     = exec_err & ~exec_err_d_r;
        irq_ev[IQ_RAM]      = ram_db_invalid & ~ram_err_d_r;
        irq_ev[IQ_AUTO_CS]  = state_r == ST_COPY && flash_copy_done;
        irq_ev[IQ_CHANGED]  = changed_set;
    end

    // write-one-to-clear, a new event wins over the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_stat_r <= '0;
        end else if (reg_wr && reg_addr == ADR_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~reg_wdata[IRQ_W-1:0]) | irq_ev;
        end else begin
            irq_stat_r <= irq_stat_r | irq_ev;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_mask_r <= '0;
        end else if (reg_wr && reg_addr == ADR_IRQ_MASK) begin
            irq_mask_r <= reg_wdata[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    // writes to the two status words are dropped; they are read-only
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADR_NONFATAL: reg_rdata <= nf_word_r;
                ADR_LOOP:     reg_rdata <= loop_word_r;
                ADR_IRQ_STAT: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_r};
                ADR_IRQ_MASK: reg_rdata <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_r};
                default:      reg_rdata <= UNMAPPED_VAL;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

`default_nettype wire

// ---- lcs_flags_asserts.sv ----
/*
 * lcs_flags_asserts: port checker for the status flag block.
 * assumes it is bound onto lcs_flags; one clock, sync reset.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_flags_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // run control
    input wire logic start_req,
    input wire logic start_mode,
    input wire logic stop_req,
    input wire logic ram_db_invalid,
    input wire logic running,
    input wire logic hot_start,
    input wire logic cold_start,
    // flash handshake
    input wire logic backup_req,
    input wire logic flash_backup_req,
    input wire logic flash_copy_req,
    input wire logic flash_copy_done
);
    // first start after reset may take the power-loss path
    logic started_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            started_r <= 1'b0;
        end else if (hot_start || cold_start) begin
            started_r <= 1'b1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_stop;
        stop_req && running |=> !running;
    endproperty
    a_stop: assert property (p_stop) else $error("still running after stop");

    property p_run;
        (hot_start || cold_start) && !stop_req |=> running;
    endproperty
    a_run: assert property (p_run) else $error("start pulse without run");

    property p_cold;
        start_req && !running && started_r && ram_db_invalid |-> ##2 (cold_start && !hot_start);
    endproperty
    a_cold: assert property (p_cold) else $error("bad data gave no cold start");

    property p_hot;
        start_req && !running && started_r && !start_mode && !ram_db_invalid |-> ##2 (hot_start && !cold_start);
    endproperty
    a_hot: assert property (p_hot) else $error("hot request not honoured");

    property p_copy;
        flash_copy_req |-> !running ##1 !cold_start;
    endproperty
    a_copy: assert property (p_copy) else $error("started before flash copy");

    property p_auto;
        cold_start |-> $past(start_req, 2) || $past(flash_copy_done);
    endproperty
    a_auto: assert property (p_auto) else $error("cold start without cause");

    property p_bkreq;
        flash_backup_req |-> $past(backup_req) && $past(running);
    endproperty
    a_bkreq: assert property (p_bkreq) else $error("flash write not requested");

    property p_bkone;
        flash_backup_req |=> !flash_backup_req;
    endproperty
    a_bkone: assert property (p_bkone) else $error("backup request repeated");
endmodule

bind lcs_flags lcs_flags_asserts u_chk (
    .clk, .reset, .start_req, .start_mode, .stop_req, .ram_db_invalid, .running,
    .hot_start, .cold_start, .backup_req, .flash_backup_req, .flash_copy_req, .flash_copy_done
);
`default_nettype wire

// ---- lcs_flash_model.sv ----
/*
 * lcs_flash_model: flash controller answering copy and backup requests.
 * assumes single-cycle request pulses on clk; answers with done pulses.
 */
`timescale 1ns/100ps
`default_nettype none
module lcs_flash_model #(
    parameter int COPY_DLY = 4,
    parameter int BK_DLY   = 60
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // requests
    input  wire logic copy_req,
    input  wire logic backup_req,
    // answers
    output logic      copy_done,
    output logic      backup_done
);
    int copy_cnt;
    int bk_cnt;

    // backup image into ram, done before the block may run
    always_ff @(posedge clk) begin
        copy_done <= 1'b0;
        if (reset) begin
            copy_cnt <= 0;
        end else if (copy_req) begin
            copy_cnt <= COPY_DLY;
        end else if (copy_cnt == 1) begin
            copy_cnt  <= 0;
            copy_done <= 1'b1;
        end else if (copy_cnt > 1) begin
            copy_cnt <= copy_cnt - 1;
        end
    end

    // slow on purpose so the busy flag is seen by a refresh
    always_ff @(posedge clk) begin
        backup_done <= 1'b0;
        if (reset) begin
            bk_cnt <= 0;
        end else if (backup_req) begin
            bk_cnt <= BK_DLY;
        end else if (bk_cnt == 1) begin
            bk_cnt      <= 0;
            backup_done <= 1'b1;
        end else if (bk_cnt > 1) begin
            bk_cnt <= bk_cnt - 1;
        end
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
/*
 * testbench: scenarios for the status flag block.
 * assumes lcs_pkg, the checker bind and the flash model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import lcs_pkg::*;
    localparam int RCNT  = 16;
    localparam int LIMIT = 20000;

    logic        clk, reset, reg_wr, reg_rd, irq, duplex_mode, right_nonfatal, left_nonfatal;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic        pv_error_input_item, mv_error_input_item, ram_db_invalid, ram_lost_at_power;
    logic [127:0] execution_error_code_item;
    logic        start_req, start_mode, stop_req, running, hot_start, cold_start;
    logic        download_strobe, backup_req, ram_write_en, flash_copy_req, flash_copy_done;
    logic        flash_backup_req, flash_backup_done;
    logic        saw_hot, saw_cold, saw_copy, cold_ok, saw_wen;
    int          n_bk, cyc, error_cnt, n_checks;

    lcs_flags #(.REFRESH_CNT(RCNT)) dut (
        .clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .duplex_mode, .right_nonfatal, .left_nonfatal, .pv_error_input_item, .mv_error_input_item,
        .execution_error_code_item, .ram_db_invalid, .ram_lost_at_power, .start_req, .start_mode,
        .stop_req, .running, .hot_start, .cold_start, .download_strobe, .backup_req, .ram_write_en,
        .flash_copy_req, .flash_copy_done, .flash_backup_req, .flash_backup_done
    );

    lcs_flash_model u_flash (
        .clk, .reset, .copy_req(flash_copy_req), .backup_req(flash_backup_req),
        .copy_done(flash_copy_done), .backup_done(flash_backup_done)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // monitors and timeout
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (hot_start === 1'b1) saw_hot = 1'b1;
        if (flash_copy_req === 1'b1) saw_copy = 1'b1;
        if (cold_start === 1'b1) begin
            saw_cold = 1'b1;
            cold_ok  = saw_copy;
        end
        if (ram_write_en === 1'b1) saw_wen = 1'b1;
        if (flash_backup_req === 1'b1) n_bk++;
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // ------------------------------------------------------------
    // register port and run control
    // ------------------------------------------------------------
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic chk(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] v;
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
        cmp(v, e);
    endtask

    task automatic settle();
        repeat (2 * RCNT + 4) @(posedge clk);
    endtask

    task automatic go(input logic mode);
        @(posedge clk);
        start_req  <= 1'b1;
        start_mode <= mode;
        {saw_hot, saw_cold, saw_copy, cold_ok} = 4'h0;
        @(posedge clk);
        start_req <= 1'b0;
        for (int i = 0; i < 200 && running !== 1'b1; i++) @(posedge clk);
    endtask

    task automatic stop();
        @(posedge clk);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_readonly();
        settle();
        wr(ADR_NONFATAL, 16'hFFFF);
        wr(ADR_LOOP, 16'hFFFF);
        settle();
        chk(ADR_NONFATAL, 16'h0000);
        chk(ADR_LOOP, 16'h0000);
        chk(4'h5, 16'h0000);
    endtask

    task automatic t_autocold();
        go(START_HOT);
        cmp({15'h0, cold_ok}, 16'h0001);
        cmp({15'h0, saw_hot}, 16'h0000);
        settle();
        chk(ADR_LOOP, 16'h0880);
    endtask

    task automatic t_boards();
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            @(posedge clk);
            {duplex_mode, right_nonfatal, left_nonfatal} <= c;
            settle();
            chk(ADR_NONFATAL, {8'h00, c[2] & c[0], c[2] & c[1], 6'h00});
        end
    endtask

    task automatic t_items();
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {mv_error_input_item, pv_error_input_item} <= i[1:0];
            settle();
            chk(ADR_LOOP, 16'h0880 | {13'h0, i[1:0], 1'b0});
        end
        for (int g = 0; g < 8; g++) begin
            @(posedge clk);
            {mv_error_input_item, pv_error_input_item} <= 2'b00;
            execution_error_code_item <= 128'(16'h8001) << (g * 16);
            settle();
            chk(ADR_LOOP, 16'h0888);
        end
        @(posedge clk);
        execution_error_code_item <= '0;
        settle();
        chk(ADR_LOOP, 16'h0880);
    endtask

    task automatic t_changed_irq();
        wr(ADR_IRQ_STAT, 16'hFFFF);
        wr(ADR_IRQ_MASK, 16'h0000);
        {saw_wen, n_bk} = '0;
        @(posedge clk);
        download_strobe <= 1'b1;
        @(posedge clk);
        download_strobe <= 1'b0;
        settle();
        cmp({15'h0, saw_wen}, 16'h0001);
        cmp(16'(n_bk), 16'h0000);
        chk(ADR_LOOP, 16'h8880);
        chk(ADR_IRQ_STAT, 16'h0010);
        cmp({15'h0, irq}, 16'h0000);
        wr(ADR_IRQ_MASK, 16'h001F);
        repeat (3) @(posedge clk);
        cmp({15'h0, irq}, 16'h0001);
        wr(ADR_IRQ_STAT, 16'h0010);
        repeat (3) @(posedge clk);
        cmp({15'h0, irq}, 16'h0000);
    endtask

    task automatic t_backup();
        n_bk = 0;
        @(posedge clk);
        backup_req <= 1'b1;
        @(posedge clk);
        backup_req <= 1'b0;
        settle();
        chk(ADR_LOOP, 16'hA880);
        settle();
        settle();
        chk(ADR_LOOP, 16'h8880);
        cmp(16'(n_bk), 16'h0001);
    endtask

    task automatic t_restart();
        stop();
        settle();
        chk(ADR_LOOP, 16'h8000);
        go(START_HOT);
        cmp({15'h0, saw_hot}, 16'h0001);
        settle();
        chk(ADR_LOOP, 16'h0800);
        @(posedge clk);
        download_strobe <= 1'b1;
        @(posedge clk);
        download_strobe <= 1'b0;
        settle();
        chk(ADR_LOOP, 16'h8800);
        stop();
        go(START_COLD);
        cmp({15'h0, saw_cold}, 16'h0001);
        settle();
        chk(ADR_LOOP, 16'h0800);
    endtask

    task automatic t_raminv();
        @(posedge clk);
        ram_db_invalid <= 1'b1;
        stop();
        go(START_HOT);
        cmp({15'h0, saw_cold}, 16'h0001);
        settle();
        chk(ADR_LOOP, 16'h0810);
        @(posedge clk);
        ram_db_invalid <= 1'b0;
        settle();
        chk(ADR_LOOP, 16'h0800);
    endtask

    initial begin
        {reset, ram_lost_at_power} = 2'b11;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {duplex_mode, right_nonfatal, left_nonfatal, pv_error_input_item, mv_error_input_item} = '0;
        {execution_error_code_item, ram_db_invalid, start_req, start_mode, stop_req} = '0;
        {download_strobe, backup_req, saw_hot, saw_cold, saw_copy, cold_ok, saw_wen} = '0;
        {n_bk, cyc, error_cnt, n_checks} = '0;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        t_readonly();
        t_autocold();
        t_boards();
        t_items();
        t_changed_irq();
        t_backup();
        t_restart();
        t_raminv();
        results();
    end
endmodule
`default_nettype wire
